/* File: logic/psr_pkg.sv */
package psr_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h9b;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h9c;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h9d;
  localparam logic [7:0] ADDR_VARIANT_VERSION = 8'ha6;
  localparam logic [7:0] ADDR_SOFTWARE_RESET = 8'ha8;
  localparam logic [7:0] ADDR_WAIT_PERIOD = 8'ha9;
  localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h8d;
  localparam logic [7:0] ADDR_INTERRUPT_BEHAVIOUR = 8'hab;
  localparam logic [7:0] ADDR_PULSE_CONTROL = 8'hae;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_ABOVE_HIGH = 7;
  localparam int BIT_BELOW_LOW = 6;
  localparam int BIT_ANY_SAT = 5;
  localparam int BIT_PROX_INT = 4;
  localparam int BIT_CAL_DONE = 3;
  localparam int BIT_ZERO_DETECT = 2;
  localparam int BIT_EMITTER_ON_SAT = 1;
  localparam int BIT_EMITTER_OFF_SAT = 0;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_LONG_WAIT = 3;
  localparam int BIT_READ_CLEAR = 7;
  localparam int BIT_SLEEP_AFTER_INT = 4;
  localparam int BIT_PULSE_CTRL_DISABLE = 6;
  localparam int BIT_POWER_ON = 0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RST_WAIT_PERIOD = 8'h00;
  localparam logic [7:0] RST_GENERAL_CONFIG = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_BEHAVIOUR = 8'h04;
  localparam logic [7:0] RST_PULSE_CONTROL = 8'h3f;
  localparam logic [7:0] RST_SOFTWARE_RESET = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [3:0] VARIANT_VERSION = 4'h5; // arbitrary value

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_HZ = 25_000_000;
  localparam int WAIT_STEP_NS = 2_780_000;
  localparam int WAIT_STEP_CYCLES = int'((64'(WAIT_STEP_NS) * CLOCK_HZ) / 1_000_000_000);
  localparam int LONG_WAIT_FACTOR = 12;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic above_high;
    logic below_low;
    logic any_sat;
    logic prox_int;
    logic cal_done;
    logic zero_detect;
    logic emitter_on_sat;
    logic emitter_off_sat;
  } psr_events_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psr_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [9:0] adc_value;
    logic [6:0] pulses;
  } psr_sample_t;
endpackage

/* File: logic/psr_wait_timer.sv */
`timescale 1ns/1ns
// down-counting wait timer: setting plus one increments, twelve times that with long_i set, each one step
module psr_wait_timer #(
  parameter int STEP_CYCLES = psr_pkg::WAIT_STEP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic start_i,
  input wire logic [7:0] setting_i,
  input wire logic long_i,
  output logic busy_o,
  output logic done_o
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [16:0] step_cnt; // cycles within one 2.78 ms step
  logic [16:0] next_step_cnt;
  logic [12:0] inc_cnt; // remaining increments, down counter
  logic [12:0] next_inc_cnt;
  logic next_done;
  logic step_pulse; // one-cycle enable from the divider

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_step_cnt = step_cnt;
    next_inc_cnt = inc_cnt;
    next_done = 1'b0;
    step_pulse = (step_cnt == 17'(STEP_CYCLES - 1));
    if (clear_i)
    begin
      // soft reset stops the wait at once
      next_step_cnt = '0;
      next_inc_cnt = '0;
    end
    else if (start_i)
    begin
      // long wait multiplies the increment count, keeping one divider
      next_step_cnt = '0;
      next_inc_cnt = long_i ? 13'((14'(setting_i) + 14'd1) * 14'(psr_pkg::LONG_WAIT_FACTOR))
                            : 13'(setting_i) + 13'd1;
    end
    else if (inc_cnt != '0)
    begin
      next_step_cnt = step_pulse ? '0 : step_cnt + 17'd1;
      if (step_pulse)
      begin
        next_inc_cnt = inc_cnt - 13'd1;
        next_done = (inc_cnt == 13'd1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      step_cnt <= '0;
      inc_cnt <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      step_cnt <= next_step_cnt;
      inc_cnt <= next_inc_cnt;
      done_o <= next_done;
    end
  end

  assign busy_o = (inc_cnt != '0);
endmodule // psr_wait_timer

/* File: logic/psr_result_format.sv */
`timescale 1ns/1ns
// shapes a converter sample into the two result bytes
module psr_result_format (
  input wire logic pulse_ctrl_on_i,
  input wire logic [9:0] adc_value_i,
  input wire logic [6:0] pulses_i,
  output logic [7:0] low_byte_o,
  output logic [7:0] high_byte_o,
  output logic [7:0] compare_byte_o
);
  // ----------------------------------------------------------------------
  // scaling
  // ----------------------------------------------------------------------
  logic [13:0] scaled; // adc * 16 / pulses, 14 bits
  logic [6:0] safe_pulses; // never divide by zero

  // a combinational divider is costly but samples arrive rarely
  always_comb
  begin
    safe_pulses = (pulses_i == 7'd0) ? 7'd1 : pulses_i;
    scaled = 14'(({adc_value_i, 4'h0}) / 14'(safe_pulses));
    if (pulse_ctrl_on_i)
    begin
      low_byte_o = scaled[7:0];
      high_byte_o = {2'b00, scaled[13:8]};
      compare_byte_o = scaled[7:0];
    end
    else
    begin
      low_byte_o = adc_value_i[9:2];
      high_byte_o = {6'b000000, adc_value_i[1:0]};
      compare_byte_o = adc_value_i[9:2];
    end
  end
endmodule // psr_result_format

/* File: logic/psr_regs.sv */
`timescale 1ns/1ns
// How it works
// - bit 7 set with interrupt above high
// - bit 6 set with interrupt below low
// - bit 5 set on any saturation
// - bit 4 set on threshold plus persistence
// - bit 3 set when calibration finishes
// - bit 2 set on zero-triggered offset trim
// - bit 1 set on emitter-on saturation
// - bit 0 set on emitter-off saturation
// - writing one clears a flag
// - read clears all flags if enabled
// - pulse control on: 14-bit result, low first
// - pulse control off: 10-bit, top eight low
// - low byte read latches high byte
// - result scaled by sixteen over pulses
// - pulses shrink as signal grows
// - off mode compares upper eight bits
// - soft reset restores defaults and sleeps
// - wait is setting plus one steps
// - long wait multiplies by twelve
// - wait timed by down counter
// - read-clear enable in bit 7
// - sleep after interrupt until flags cleared
module psr_regs (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire psr_pkg::psr_bus_req_t bus_req_i,
  output logic [7:0] bus_rdata_o,
  input wire psr_pkg::psr_sample_t sample_i,
  input wire logic [7:0] low_threshold_i,
  input wire logic [7:0] high_threshold_i,
  input wire logic persistence_met_i,
  input wire logic cal_done_i,
  input wire logic zero_trim_i,
  input wire logic emitter_on_sat_i,
  input wire logic emitter_off_sat_i,
  output logic [6:0] pulse_limit_o,
  output logic oscillator_on_o,
  output logic wait_busy_o,
  output logic wait_done_o,
  output logic soft_reset_o
);
  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync; // two-stage release of the async reset
  logic rst_n; // released reset used everywhere else

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  psr_pkg::psr_events_t flags; // event flags register
  psr_pkg::psr_events_t next_flags;
  logic [7:0] wait_setting; // wait period setting
  logic [7:0] next_wait_setting;
  logic [7:0] general_cfg; // holds power-on and long wait
  logic [7:0] next_general_cfg;
  logic [7:0] int_cfg; // read clear and sleep after interrupt
  logic [7:0] next_int_cfg;
  logic [7:0] pulse_cfg; // pulse control disable
  logic [7:0] next_pulse_cfg;
  logic [7:0] res_low; // result low byte
  logic [7:0] next_res_low;
  logic [7:0] res_high; // live high byte
  logic [7:0] next_res_high;
  logic [7:0] res_high_hold; // high byte captured by a low read
  logic [7:0] next_res_high_hold;
  logic [6:0] pulse_limit; // pulses the next cycle may emit
  logic [6:0] next_pulse_limit;
  logic sleeping; // oscillator parked after an interrupt
  logic next_sleeping;
  logic [7:0] next_rdata;
  logic soft_reset; // one-cycle soft reset strobe
  logic next_soft_reset;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  logic wr_hit_flags;
  logic rd_hit_flags;
  logic pulse_ctrl_on;
  logic [7:0] fmt_low;
  logic [7:0] fmt_high;
  logic [7:0] fmt_cmp;
  logic above; // compare result above high threshold
  logic below; // compare result below low threshold
  logic int_event; // interrupt fires this cycle
  logic wait_done;
  logic wait_busy;
  logic wait_start;

  assign wr_hit_flags = bus_req_i.wr && (bus_req_i.addr == psr_pkg::ADDR_EVENT_FLAGS);
  assign rd_hit_flags = bus_req_i.rd && (bus_req_i.addr == psr_pkg::ADDR_EVENT_FLAGS);
  assign pulse_ctrl_on = !pulse_cfg[psr_pkg::BIT_PULSE_CTRL_DISABLE];
  assign above = sample_i.valid && (fmt_cmp > high_threshold_i);
  assign below = sample_i.valid && (fmt_cmp < low_threshold_i);
  assign int_event = persistence_met_i && (above || below);
  assign wait_start = sample_i.valid && !sleeping;

  // ----------------------------------------------------------------------
  // result formatting and wait timer
  // ----------------------------------------------------------------------
  psr_result_format u_format (
    .pulse_ctrl_on_i(pulse_ctrl_on),
    .adc_value_i(sample_i.adc_value),
    .pulses_i(sample_i.pulses),
    .low_byte_o(fmt_low),
    .high_byte_o(fmt_high),
    .compare_byte_o(fmt_cmp)
  );

  psr_wait_timer u_wait (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .clear_i(soft_reset),
    .start_i(wait_start),
    .setting_i(wait_setting),
    .long_i(general_cfg[psr_pkg::BIT_LONG_WAIT]),
    .busy_o(wait_busy),
    .done_o(wait_done)
  );

  // ----------------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------------
  // clearing first, then hardware sets, so a same-cycle event survives
  always_comb
  begin
    next_flags = flags;
    if (wr_hit_flags)
      next_flags = flags & ~bus_req_i.wdata;
    if (rd_hit_flags && int_cfg[psr_pkg::BIT_READ_CLEAR])
      next_flags = '0;
    if (!next_flags.prox_int)
    begin
      next_flags.above_high = 1'b0;
      next_flags.below_low = 1'b0;
    end
    if (int_event)
    begin
      next_flags.prox_int = 1'b1;
      next_flags.above_high = above || next_flags.above_high;
      next_flags.below_low = below || next_flags.below_low;
    end
    if (emitter_on_sat_i || emitter_off_sat_i)
      next_flags.any_sat = 1'b1;
    if (cal_done_i)
      next_flags.cal_done = 1'b1;
    if (zero_trim_i)
      next_flags.zero_detect = 1'b1;
    if (emitter_on_sat_i)
      next_flags.emitter_on_sat = 1'b1;
    if (emitter_off_sat_i)
      next_flags.emitter_off_sat = 1'b1;
    if (soft_reset)
      next_flags = psr_pkg::RST_EVENT_FLAGS;
  end

  // ----------------------------------------------------------------------
  // configuration, result and sleep
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_wait_setting = wait_setting;
    next_general_cfg = general_cfg;
    next_int_cfg = int_cfg;
    next_pulse_cfg = pulse_cfg;
    next_res_low = res_low;
    next_res_high = res_high;
    next_res_high_hold = res_high_hold;
    next_pulse_limit = pulse_limit;
    next_sleeping = sleeping;
    next_soft_reset = 1'b0;
    if (bus_req_i.wr)
    begin
      // result and version addresses fall through untouched
      unique case (bus_req_i.addr)
        psr_pkg::ADDR_WAIT_PERIOD: next_wait_setting = bus_req_i.wdata;
        psr_pkg::ADDR_GENERAL_CONFIG: next_general_cfg = bus_req_i.wdata;
        psr_pkg::ADDR_INTERRUPT_BEHAVIOUR: next_int_cfg = bus_req_i.wdata;
        psr_pkg::ADDR_PULSE_CONTROL: next_pulse_cfg = bus_req_i.wdata;
        psr_pkg::ADDR_SOFTWARE_RESET:
          next_soft_reset = bus_req_i.wdata[psr_pkg::BIT_SOFT_RESET];
        default: next_soft_reset = 1'b0;
      endcase
    end
    if (sample_i.valid)
    begin
      next_res_low = fmt_low;
      next_res_high = fmt_high;
      // fewer pulses for strong echoes, more for weak ones
      if (pulse_ctrl_on && sample_i.adc_value[9] && pulse_limit > 7'd1)
        next_pulse_limit = pulse_limit - 7'd1;
      else if (pulse_ctrl_on && !sample_i.adc_value[9] && pulse_limit < 7'd64)
        next_pulse_limit = pulse_limit + 7'd1;
    end
    if (bus_req_i.rd && bus_req_i.addr == psr_pkg::ADDR_RESULT_LOW)
      next_res_high_hold = res_high;
    if (int_event && int_cfg[psr_pkg::BIT_SLEEP_AFTER_INT])
      next_sleeping = 1'b1;
    else if (sleeping && next_flags == '0)
      next_sleeping = 1'b0;
    if (soft_reset)
    begin
      // every register back to default, device asleep (power bit 0)
      next_wait_setting = psr_pkg::RST_WAIT_PERIOD;
      next_general_cfg = psr_pkg::RST_GENERAL_CONFIG;
      next_int_cfg = psr_pkg::RST_INTERRUPT_BEHAVIOUR;
      next_pulse_cfg = psr_pkg::RST_PULSE_CONTROL;
      next_res_low = psr_pkg::RST_RESULT;
      next_res_high = psr_pkg::RST_RESULT;
      next_res_high_hold = psr_pkg::RST_RESULT;
      next_pulse_limit = 7'd64;
      next_sleeping = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read data, registered one cycle after the read strobe
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    if (bus_req_i.rd)
    begin
      unique case (bus_req_i.addr)
        psr_pkg::ADDR_EVENT_FLAGS: next_rdata = flags;
        psr_pkg::ADDR_RESULT_LOW: next_rdata = res_low;
        psr_pkg::ADDR_RESULT_HIGH: next_rdata = res_high_hold;
        psr_pkg::ADDR_VARIANT_VERSION: next_rdata = {4'h0, psr_pkg::VARIANT_VERSION};
        psr_pkg::ADDR_SOFTWARE_RESET: next_rdata = psr_pkg::RST_SOFTWARE_RESET;
        psr_pkg::ADDR_WAIT_PERIOD: next_rdata = wait_setting;
        psr_pkg::ADDR_GENERAL_CONFIG: next_rdata = general_cfg;
        psr_pkg::ADDR_INTERRUPT_BEHAVIOUR: next_rdata = int_cfg;
        psr_pkg::ADDR_PULSE_CONTROL: next_rdata = pulse_cfg;
        default: next_rdata = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags <= psr_pkg::RST_EVENT_FLAGS;
      wait_setting <= psr_pkg::RST_WAIT_PERIOD;
      general_cfg <= psr_pkg::RST_GENERAL_CONFIG;
      int_cfg <= psr_pkg::RST_INTERRUPT_BEHAVIOUR;
      pulse_cfg <= psr_pkg::RST_PULSE_CONTROL;
      res_low <= psr_pkg::RST_RESULT;
      res_high <= psr_pkg::RST_RESULT;
      res_high_hold <= psr_pkg::RST_RESULT;
      pulse_limit <= 7'd64;
      sleeping <= 1'b0;
      bus_rdata_o <= 8'h00;
      soft_reset <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      wait_setting <= next_wait_setting;
      general_cfg <= next_general_cfg;
      int_cfg <= next_int_cfg;
      pulse_cfg <= next_pulse_cfg;
      res_low <= next_res_low;
      res_high <= next_res_high;
      res_high_hold <= next_res_high_hold;
      pulse_limit <= next_pulse_limit;
      sleeping <= next_sleeping;
      bus_rdata_o <= next_rdata;
      soft_reset <= next_soft_reset;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // with pulse control off the full setting applies every cycle
  assign pulse_limit_o = pulse_ctrl_on ? pulse_limit : 7'd64;
  assign oscillator_on_o = general_cfg[psr_pkg::BIT_POWER_ON] && !sleeping;
  assign wait_busy_o = wait_busy;
  assign wait_done_o = wait_done;
  assign soft_reset_o = soft_reset;
endmodule // psr_regs

/* File: dv/psr_regs_asserts.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// port-level checker for the register bank
// ----------------------------------------------------------------------
module psr_regs_asserts (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire psr_pkg::psr_bus_req_t bus_req_i,
  input wire logic [7:0] bus_rdata_o,
  input wire psr_pkg::psr_sample_t sample_i,
  input wire logic cal_done_i,
  input wire logic zero_trim_i,
  input wire logic emitter_on_sat_i,
  input wire logic emitter_off_sat_i,
  input wire logic [6:0] pulse_limit_o,
  input wire logic oscillator_on_o,
  input wire logic wait_busy_o,
  input wire logic wait_done_o,
  input wire logic soft_reset_o
);
  // shortest legal wait, with slack
  localparam int MIN_WAIT = psr_pkg::WAIT_STEP_CYCLES - 4;
  logic quiet; // no hardware event and no write this cycle
  logic read_clear; // shadow of the read-clear enable
  logic next_read_clear;
  logic power_on; // shadow of the power bit
  logic next_power_on;
  logic [31:0] busy_cnt; // cycles spent waiting, kept until done
  logic [31:0] next_busy_cnt;
  assign quiet = !(cal_done_i | zero_trim_i | emitter_on_sat_i | emitter_off_sat_i
                   | sample_i.valid | bus_req_i.wr);

  // shadows follow host writes and soft reset
  always_comb
  begin
    next_read_clear = read_clear;
    next_power_on = power_on;
    if (soft_reset_o)
    begin
      next_read_clear = 1'b0;
      next_power_on = 1'b0;
    end
    else if (bus_req_i.wr && bus_req_i.addr == psr_pkg::ADDR_INTERRUPT_BEHAVIOUR)
      next_read_clear = bus_req_i.wdata[psr_pkg::BIT_READ_CLEAR];
    else if (bus_req_i.wr && bus_req_i.addr == psr_pkg::ADDR_GENERAL_CONFIG)
      next_power_on = bus_req_i.wdata[psr_pkg::BIT_POWER_ON];
    // zero while the timer is idle, so a cut wait leaves no count behind
    if (wait_busy_o && !wait_done_o)
      next_busy_cnt = busy_cnt + 32'h1;
    else
      next_busy_cnt = '0;
  end

  // helper registers only
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      read_clear <= 1'b0;
      power_on <= 1'b0;
      busy_cnt <= '0;
    end
    else
    begin
      read_clear <= next_read_clear;
      power_on <= next_power_on;
      busy_cnt <= next_busy_cnt;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_flag_read;
    bus_req_i.rd && bus_req_i.addr == psr_pkg::ADDR_EVENT_FLAGS && quiet;
  endsequence
  sequence s_rc_read;
    bus_req_i.rd && bus_req_i.addr == psr_pkg::ADDR_EVENT_FLAGS && quiet && read_clear;
  endsequence
  sequence s_clear_all;
    bus_req_i.wr && bus_req_i.addr == psr_pkg::ADDR_EVENT_FLAGS
      && bus_req_i.wdata == 8'hff && !sample_i.valid;
  endsequence

  chk_rdata_idle: assert property (!bus_req_i.rd |=> bus_rdata_o == 8'h00)
    else $error("read data not quiet without a read");
  chk_version_read: assert property ((bus_req_i.rd && bus_req_i.addr == psr_pkg::ADDR_VARIANT_VERSION)
    |=> bus_rdata_o == {4'h0, psr_pkg::VARIANT_VERSION})
    else $error("version field wrong");
  chk_flags_w1c: assert property (s_clear_all ##1 quiet ##1 s_flag_read |=> bus_rdata_o == 8'h00)
    else $error("flags survived a write of ones");
  chk_read_clear: assert property (s_rc_read ##1 quiet [*2] ##1 s_flag_read |=> bus_rdata_o == 8'h00)
    else $error("flags survived a clearing read");
  chk_wait_readback: assert property ((bus_req_i.wr && bus_req_i.addr == psr_pkg::ADDR_WAIT_PERIOD)
    ##2 (bus_req_i.rd && bus_req_i.addr == psr_pkg::ADDR_WAIT_PERIOD)
    |=> bus_rdata_o == $past(bus_req_i.wdata, 3))
    else $error("wait setting readback wrong");
  chk_soft_pulse: assert property ((bus_req_i.wr && bus_req_i.addr == psr_pkg::ADDR_SOFTWARE_RESET
    && bus_req_i.wdata[psr_pkg::BIT_SOFT_RESET]) |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse missing");
  chk_reset_sleep: assert property (soft_reset_o |=> !oscillator_on_o)
    else $error("oscillator still on after soft reset");
  chk_osc_power: assert property (oscillator_on_o |-> power_on)
    else $error("oscillator on without power bit");
  chk_done_pulse: assert property (wait_done_o |=> !wait_done_o)
    else $error("wait done longer than one cycle");
  chk_wait_length: assert property (wait_done_o |-> busy_cnt >= MIN_WAIT)
    else $error("wait ended too early");
  chk_limit_range: assert property (pulse_limit_o >= 7'd1 && pulse_limit_o <= 7'd64)
    else $error("pulse limit out of range");
endmodule // psr_regs_asserts

bind psr_regs psr_regs_asserts i_chk (.ref_clk_i, .arst_n_i, .bus_req_i, .bus_rdata_o,
  .sample_i, .cal_done_i, .zero_trim_i, .emitter_on_sat_i, .emitter_off_sat_i,
  .pulse_limit_o, .oscillator_on_o, .wait_busy_o, .wait_done_o, .soft_reset_o);

/* File: dv/psr_host_model.sv */
`timescale 1ns/1ns
// host on the register bus, one request at a time
module psr_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] bus_rdata_i,
  output psr_pkg::psr_bus_req_t bus_req_o
);
  initial bus_req_o = '0;

  // idle bus shows inverted address and data
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    bus_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // read data stands one cycle after the taking edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
    @(posedge ref_clk_i);
    bus_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: a};
    @(posedge ref_clk_i);
    d = bus_rdata_i;
  endtask
endmodule // psr_host_model

/* File: dv/psr_regs_bench.sv */
`timescale 1ns/1ns
module psr_regs_bench;
  logic ref_clk_i;
  logic arst_n_i;
  psr_pkg::psr_bus_req_t bus_req;
  logic [7:0] rdata;
  psr_pkg::psr_sample_t sample;
  logic [3:0] ev; // calibration, zero trim, emitter on, emitter off
  logic [6:0] plimit;
  logic osc;
  logic wbusy;
  logic wdone;
  int fail_count;
  int n_compared;
  int i;
  // short offsets for the calls below
  localparam FLG = psr_pkg::ADDR_EVENT_FLAGS;
  localparam RLO = psr_pkg::ADDR_RESULT_LOW;
  localparam RHI = psr_pkg::ADDR_RESULT_HIGH;
  localparam ICF = psr_pkg::ADDR_INTERRUPT_BEHAVIOUR;
  localparam GCF = psr_pkg::ADDR_GENERAL_CONFIG;
  localparam WTP = psr_pkg::ADDR_WAIT_PERIOD;
  localparam SRS = psr_pkg::ADDR_SOFTWARE_RESET;

  // thresholds held fixed: above-high is 0x80, below-low is 0x20
  psr_regs i_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .bus_req_i(bus_req),
    .bus_rdata_o(rdata), .sample_i(sample), .low_threshold_i(8'h20),
    .high_threshold_i(8'h80), .persistence_met_i(1'b1), .cal_done_i(ev[3]),
    .zero_trim_i(ev[2]), .emitter_on_sat_i(ev[1]), .emitter_off_sat_i(ev[0]),
    .pulse_limit_o(plimit), .oscillator_on_o(osc), .wait_busy_o(wbusy),
    .wait_done_o(wdone), .soft_reset_o());
  psr_host_model i_host (.ref_clk_i(ref_clk_i), .bus_rdata_i(rdata), .bus_req_o(bus_req));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.read_reg(a, d);
    chk(d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(a, d);
  endtask
  // one conversion, then settle
  task automatic smp(input logic [9:0] a, input logic [6:0] p);
    @(posedge ref_clk_i);
    sample <= '{valid: 1'b1, adc_value: a, pulses: p};
    @(posedge ref_clk_i);
    sample.valid <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic pulse_ev(input logic [3:0] v);
    @(posedge ref_clk_i);
    ev <= v;
    @(posedge ref_clk_i);
    ev <= 4'h0;
  endtask
  task automatic stop_test;
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    arst_n_i = 1'b0;
    sample = '0;
    ev = 4'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (20) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    // defaults, read-only places and an unmapped address
    wr(RLO, 8'hff);
    wr(psr_pkg::ADDR_VARIANT_VERSION, 8'hff);
    rd(FLG, 8'h00);
    rd(RLO, 8'h00);
    rd(RHI, 8'h00);
    rd(psr_pkg::ADDR_VARIANT_VERSION, {4'h0, psr_pkg::VARIANT_VERSION});
    rd(SRS, 8'h00);
    rd(WTP, 8'h00);
    rd(8'h10, 8'h00);
    // event flags, zero writes, write-one-to-clear
    pulse_ev(4'hf);
    rd(FLG, 8'h2f);
    wr(FLG, 8'h00);
    rd(FLG, 8'h2f);
    wr(FLG, 8'h01);
    rd(FLG, 8'h2e);
    wr(FLG, 8'hff);
    rd(FLG, 8'h00);
    // clearing read
    wr(ICF, 8'h84);
    pulse_ev(4'h8);
    rd(FLG, 8'h08);
    rd(FLG, 8'h00);
    wr(ICF, 8'h04);
    // pulse control off: 10-bit layout, upper byte compared
    wr(psr_pkg::ADDR_PULSE_CONTROL, 8'h7f);
    smp(10'h2d5, 7'h40);
    chk({1'b0, plimit}, 8'h40);
    rd(RLO, 8'hb5);
    rd(RHI, 8'h01);
    rd(FLG, 8'h90);
    wr(FLG, 8'h10);
    rd(FLG, 8'h00);
    // sleep after interrupt until the host clears
    wr(GCF, 8'h01);
    wr(ICF, 8'h14);
    smp(10'h004, 7'h40);
    rd(FLG, 8'h50);
    chk({7'h0, osc}, 8'h00);
    wr(FLG, 8'hff);
    rd(FLG, 8'h00);
    chk({7'h0, osc}, 8'h01);
    wr(ICF, 8'h04);
    // pulse control on: scaled 14-bit result
    wr(psr_pkg::ADDR_PULSE_CONTROL, 8'h3f);
    smp(10'h123, 7'h4);
    rd(RLO, 8'h8c);
    smp(10'h3ff, 7'h1);
    rd(RHI, 8'h04);
    rd(RLO, 8'hf0);
    rd(RHI, 8'h3f);
    smp(10'h200, 7'h1);
    chk({1'b0, plimit}, 8'h3e);
    wr(FLG, 8'hff);
    // long wait: a zero setting loads twelve increments
    wr(GCF, 8'h09);
    smp(10'h010, 7'h1);
    chk(8'(i_dut.u_wait.inc_cnt), 8'h0c);
    // soft reset restores defaults and sleeps
    wr(WTP, 8'h55);
    rd(WTP, 8'h55);
    wr(GCF, 8'h01);
    wr(SRS, 8'h01);
    repeat (3) @(posedge ref_clk_i);
    chk({7'h0, osc}, 8'h00);
    rd(WTP, 8'h00);
    rd(SRS, 8'h00);
    rd(RLO, 8'h00);
    // shortest wait: one step, counted down
    wr(GCF, 8'h01);
    smp(10'h010, 7'h1);
    chk({7'h0, wbusy}, 8'h01);
    for (i = 0; i < psr_pkg::WAIT_STEP_CYCLES + 20; i++)
    begin
      @(posedge ref_clk_i);
      if (wdone === 1'b1)
        break;
    end
    chk({7'h0, i >= psr_pkg::WAIT_STEP_CYCLES - 8}, 8'h01);
    chk({7'h0, i < psr_pkg::WAIT_STEP_CYCLES + 20}, 8'h01);
    stop_test();
  end
endmodule // psr_regs_bench
